/* dsd_pkg.sv */
// Package with address map, mode codes and access carriers for the decoder.
package dsd_pkg;

    localparam int unsigned PROG_WORDS_SMALL = 2048;
    localparam int unsigned PROG_WORDS_LARGE = 4096;
    localparam int unsigned PC_W_SMALL       = 11;
    localparam int unsigned PC_W_LARGE       = 12;
    localparam int unsigned PROG_DATA_W      = 16;

    localparam logic [15:0] WREG_LAST   = 16'h001F;
    localparam logic [15:0] IO_FIRST    = 16'h0020;
    localparam logic [15:0] IO_LAST     = 16'h005F;
    localparam logic [15:0] EXT_FIRST   = 16'h0060;
    localparam logic [15:0] EXT_LAST    = 16'h00FF;
    localparam logic [15:0] SRAM_FIRST  = 16'h0100;
    localparam logic [15:0] SRAM_LAST_S = 16'h01FF;
    localparam logic [15:0] SRAM_LAST_L = 16'h02FF;
    localparam logic [15:0] IO_OFFSET   = 16'h0020;
    localparam logic [5:0]  BIT_IO_LAST = 6'h1F;
    localparam logic [5:0]  DISP_MAX    = 6'h3F;

    localparam logic [4:0] PTR_A_LO = 5'h1A;
    localparam logic [4:0] PTR_B_LO = 5'h1C;
    localparam logic [4:0] PTR_C_LO = 5'h1E;

    localparam logic [5:0] SCRATCH0_IO = 6'h00;
    localparam logic [5:0] SCRATCH1_IO = 6'h01;
    localparam logic [5:0] SCRATCH2_IO = 6'h02;
    localparam int unsigned SCRATCH_N  = 3;

    typedef enum logic [2:0] {
        OP_NONE    = 3'b000,
        OP_LOAD    = 3'b001,
        OP_STORE   = 3'b010,
        OP_IO_LOAD = 3'b011,
        OP_IO_STORE= 3'b100,
        OP_BIT_SET = 3'b101,
        OP_BIT_CLR = 3'b110,
        OP_BIT_TST = 3'b111
    } dsd_op_t;

    typedef enum logic [2:0] {
        AM_DIRECT = 3'b000,
        AM_IND    = 3'b001,
        AM_DISP   = 3'b010,
        AM_PREDEC = 3'b011,
        AM_POSTINC= 3'b100
    } dsd_mode_t;

    typedef enum logic [1:0] {
        PS_A = 2'b00,
        PS_B = 2'b01,
        PS_C = 2'b10
    } dsd_ptr_t;

    typedef enum logic [2:0] {
        RG_WREG = 3'b000,
        RG_IO   = 3'b001,
        RG_EXT  = 3'b010,
        RG_SRAM = 3'b011,
        RG_NONE = 3'b100
    } dsd_region_t;

    typedef struct packed {
        dsd_op_t     op;
        dsd_mode_t   mode;
        dsd_ptr_t    ptr;
        logic [15:0] addr;
        logic [5:0]  disp;
        logic [2:0]  bit_sel;
        logic [7:0]  wdata;
    } dsd_req_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  rdata;
        logic        bit_val;
        dsd_region_t region;
    } dsd_rsp_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SRAM = 2'b01
    } dsd_state_t;

endpackage

/* dsd_decoder.sv */
// Data space address decoder with working registers, scratch and SRAM.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// [RULE1] Program memory is 16-bit words, 2048/4096.
// [RULE2] Program counter 11 or 12 bits wide.
// [RULE3] Addresses 0..31 select working registers.
// [RULE4] Addresses 0x20..0x5F select short peripheral region.
// [RULE5] Short I/O address 0x00..0x3F spans region.
// [RULE6] Data address equals short address plus 0x20.
// [RULE7] Short 0x00..0x1F allow bit set/clear/test.
// [RULE8] 0x60..0xFF extended region, data ops only.
// [RULE9] SRAM from 0x100 to 0x1FF or 0x2FF.
// [RULE10] Long address is a 16-bit field.
// [RULE11] Direct addressing reaches whole data space.
// [RULE12] Displacement: pointer B/C plus up to 63.
// [RULE13] Pre-decrement updates pointer before access.
// [RULE14] Post-increment accesses then bumps pointer.
// [RULE15] Pointers live in working registers 26..31.
// [RULE16] All modes work across whole volatile space.
// [RULE17] SRAM access completes in two cycles.
// [RULE18] Three scratch registers store and bit-operate.
// [RULE19] Software writes reserved bits as zero.
// [RULE20] Unmapped reads return zero, writes ignored.
module dsd_decoder
    import dsd_pkg::*;
#(
    parameter bit LARGE = 1'b1
) (
    input  wire logic                 clock,
    input  wire logic                 rst_b,
    input  wire logic                 req_valid,
    input  wire dsd_req_t             req,
    output logic                      req_ready,
    output dsd_rsp_t                  rsp,
    input  wire logic [PC_W_LARGE-1:0] pc_next,
    input  wire logic                 pc_load,
    output logic [PC_W_LARGE-1:0]     program_counter,
    output logic [PROG_DATA_W-1:0]    prog_word,
    input  wire logic                 prog_we,
    input  wire logic [PROG_DATA_W-1:0] prog_wdata,
    output logic [7:0]                ext_wdata,
    output logic [7:0]                ext_addr,
    output logic                      ext_we,
    input  wire logic [7:0]           ext_rdata,
    input  wire logic                 ext_hit
);

    localparam int unsigned PROG_WORDS = LARGE ? PROG_WORDS_LARGE
                                               : PROG_WORDS_SMALL;
    localparam int unsigned PC_W  = LARGE ? PC_W_LARGE : PC_W_SMALL;
    localparam logic [15:0] SRAM_LAST = LARGE ? SRAM_LAST_L : SRAM_LAST_S;
    localparam int unsigned SRAM_N = int'(SRAM_LAST - SRAM_FIRST) + 1;
    localparam int unsigned WREG_N = int'(WREG_LAST) + 1;

    logic [7:0]             wreg_q [WREG_N];
    logic [7:0]             wreg_d [WREG_N];
    logic [7:0]             scr_q  [SCRATCH_N];
    logic [7:0]             scr_d  [SCRATCH_N];
    logic [7:0]             sram   [SRAM_N];
    logic [PROG_DATA_W-1:0] prog   [PROG_WORDS];
    logic [PC_W_LARGE-1:0]  pc_q;
    logic [PC_W_LARGE-1:0]  pc_d;
    dsd_state_t             state_q;
    dsd_state_t             state_d;
    dsd_rsp_t               rsp_q;
    dsd_rsp_t               rsp_d;
    logic [15:0]            sram_idx_q;
    logic [15:0]            sram_idx_d;
    logic                   sram_we;
    logic [15:0]            sram_widx;
    logic [7:0]             sram_wdat;
    logic [15:0]            eff_addr;
    logic [15:0]            ptr_val;
    logic [15:0]            ptr_new;
    logic                   ptr_upd;
    logic [4:0]             ptr_lo;
    dsd_region_t            region;
    logic                   is_io_op;
    logic                   is_bit_op;
    logic                   is_write;
    logic [7:0]             cur_val;
    logic [7:0]             new_val;
    logic [7:0]             bit_mask;
    logic [1:0]             scr_hit;
    logic                   scr_sel;
    logic [5:0]             io_short;

    // Program memory: word-addressed from 0 by the counter. [RULE1] [RULE2]
    always_comb begin
        pc_d = pc_q;
        if (pc_load) begin
            pc_d = pc_next & PC_W_LARGE'(PROG_WORDS - 1); // [RULE2]
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pc_q <= '0;
        end else begin
            pc_q <= pc_d;
        end
    end

    always_ff @(posedge clock) begin
        if (prog_we) begin
            prog[pc_q[PC_W-1:0]] <= prog_wdata; // [RULE1]
        end
        prog_word <= prog[pc_q[PC_W-1:0]];
    end

    assign program_counter = pc_q;

    // Address formation per mode.
    always_comb begin
        is_io_op  = (req.op == OP_IO_LOAD) || (req.op == OP_IO_STORE) ||
                    (req.op == OP_BIT_SET) || (req.op == OP_BIT_CLR) ||
                    (req.op == OP_BIT_TST);
        is_bit_op = (req.op == OP_BIT_SET) || (req.op == OP_BIT_CLR) ||
                    (req.op == OP_BIT_TST);
        is_write  = (req.op == OP_STORE) || (req.op == OP_IO_STORE) ||
                    (req.op == OP_BIT_SET) || (req.op == OP_BIT_CLR);
        unique case (req.ptr)
            PS_A:    ptr_lo = PTR_A_LO; // [RULE15]
            PS_B:    ptr_lo = PTR_B_LO;
            PS_C:    ptr_lo = PTR_C_LO;
            default: ptr_lo = PTR_C_LO;
        endcase
        ptr_val  = {wreg_q[ptr_lo + 5'd1], wreg_q[ptr_lo]}; // [RULE15]
        ptr_new  = ptr_val;
        ptr_upd  = 1'b0;
        io_short = req.addr[5:0]; // [RULE5]
        eff_addr = req.addr; // [RULE10] [RULE11]
        if (is_io_op) begin
            eff_addr = {10'h000, io_short} + IO_OFFSET; // [RULE5] [RULE6]
        end else begin
            unique case (req.mode)
                AM_DIRECT: eff_addr = req.addr; // [RULE11]
                AM_IND:    eff_addr = ptr_val; // [RULE16]
                AM_DISP: begin
                    // Only pointers B and C carry a displacement.
                    eff_addr = ptr_val + ((req.ptr == PS_A) ? 16'h0000 :
                               {10'h000, req.disp & DISP_MAX}); // [RULE12]
                end
                AM_PREDEC: begin
                    ptr_new  = ptr_val - 16'h0001;
                    eff_addr = ptr_new; // [RULE13]
                    ptr_upd  = 1'b1;
                end
                AM_POSTINC: begin
                    eff_addr = ptr_val; // [RULE14]
                    ptr_new  = ptr_val + 16'h0001;
                    ptr_upd  = 1'b1;
                end
                default:   eff_addr = req.addr;
            endcase
        end
        // Region decode over the whole space. [RULE16]
        if (eff_addr <= WREG_LAST) begin
            region = RG_WREG; // [RULE3]
        end else if (eff_addr <= IO_LAST) begin
            region = RG_IO; // [RULE4]
        end else if (eff_addr <= EXT_LAST) begin
            region = is_io_op ? RG_NONE : RG_EXT; // [RULE8]
        end else if (eff_addr <= SRAM_LAST) begin
            region = RG_SRAM; // [RULE9]
        end else begin
            region = RG_NONE; // [RULE20]
        end
        // Bit operations only reach the low half of the short region.
        if (is_bit_op && (io_short > BIT_IO_LAST)) begin
            region = RG_NONE; // [RULE7]
        end
    end

    always_comb begin
        scr_hit = 2'd0;
        scr_sel = 1'b0;
        if (region == RG_IO) begin
            unique case (eff_addr[5:0] - IO_OFFSET[5:0])
                SCRATCH0_IO: begin
                    scr_hit = 2'd0;
                    scr_sel = 1'b1;
                end
                SCRATCH1_IO: begin
                    scr_hit = 2'd1;
                    scr_sel = 1'b1;
                end
                SCRATCH2_IO: begin
                    scr_hit = 2'd2;
                    scr_sel = 1'b1;
                end
                default:     scr_sel = 1'b0;
            endcase
        end
        unique case (region)
            RG_WREG: cur_val = wreg_q[eff_addr[4:0]];
            RG_IO:   cur_val = scr_sel ? scr_q[scr_hit] : 8'h00; // [RULE20]
            RG_EXT:  cur_val = ext_hit ? ext_rdata : 8'h00; // [RULE20]
            default: cur_val = 8'h00;
        endcase
        bit_mask = 8'h01 << req.bit_sel;
        unique case (req.op)
            OP_BIT_SET: new_val = cur_val | bit_mask; // [RULE7] [RULE18]
            OP_BIT_CLR: new_val = cur_val & ~bit_mask; // [RULE7] [RULE18]
            default:    new_val = req.wdata;
        endcase
    end

    // Register state and SRAM sequencing.
    always_comb begin
        state_d    = state_q;
        rsp_d      = rsp_q;
        rsp_d.valid = 1'b0;
        sram_idx_d = sram_idx_q;
        sram_we    = 1'b0;
        sram_widx  = eff_addr - SRAM_FIRST;
        sram_wdat  = new_val;
        ext_we     = 1'b0;
        for (int i = 0; i < WREG_N; i++) begin
            wreg_d[i] = wreg_q[i];
        end
        for (int i = 0; i < SCRATCH_N; i++) begin
            scr_d[i] = scr_q[i];
        end
        unique case (state_q)
            ST_IDLE: begin
                if (req_valid) begin
                    rsp_d.region = region;
                    // The pointer bump goes in first, so a store that lands
                    // on the pointer's own register keeps the stored byte.
                    if (ptr_upd) begin
                        wreg_d[ptr_lo] = ptr_new[7:0]; // [RULE13] [RULE14]
                        wreg_d[ptr_lo + 5'd1] = ptr_new[15:8];
                    end
                    if (region == RG_SRAM) begin
                        // Second cycle returns the data. [RULE17]
                        sram_idx_d = eff_addr - SRAM_FIRST;
                        sram_we    = is_write;
                        state_d    = ST_SRAM;
                    end else begin
                        rsp_d.valid   = 1'b1;
                        rsp_d.rdata   = cur_val;
                        rsp_d.bit_val = cur_val[req.bit_sel]; // [RULE7]
                        if (is_write && region == RG_WREG) begin
                            wreg_d[eff_addr[4:0]] = new_val; // [RULE3]
                        end
                        if (is_write && scr_sel) begin
                            scr_d[scr_hit] = new_val; // [RULE18]
                        end
                        ext_we = is_write && (region == RG_EXT); // [RULE8]
                    end
                end
            end
            ST_SRAM: begin
                // The array took a store on the accept edge, so this read
                // returns the byte just written.
                rsp_d.valid   = 1'b1;
                rsp_d.rdata   = sram[sram_idx_q[$clog2(SRAM_N)-1:0]];
                rsp_d.bit_val = 1'b0;
                state_d       = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= ST_IDLE;
            rsp_q      <= '0;
            sram_idx_q <= '0;
            for (int i = 0; i < WREG_N; i++) begin
                wreg_q[i] <= 8'h00;
            end
            for (int i = 0; i < SCRATCH_N; i++) begin
                scr_q[i] <= 8'h00;
            end
        end else begin
            state_q    <= state_d;
            rsp_q      <= rsp_d;
            sram_idx_q <= sram_idx_d;
            wreg_q     <= wreg_d;
            scr_q      <= scr_d;
        end
    end

    always_ff @(posedge clock) begin
        if (sram_we) begin
            sram[sram_widx[$clog2(SRAM_N)-1:0]] <= sram_wdat; // [RULE17]
        end
    end

    // Ready drops for the data cycle of an array access, which keeps a
    // second request from overlapping the array read.
    assign req_ready = (state_q == ST_IDLE);
    assign rsp       = rsp_q;
    // The extended bank answers in the accept cycle, so its address and
    // data stay combinational.
    assign ext_addr  = eff_addr[7:0];
    assign ext_wdata = new_val;

endmodule

`default_nettype wire

/* dsd_decoder_monitor.sv */
// Checker of decoder port timing, region selection and counter loading.
`timescale 1ns/1ns
`default_nettype none
module dsd_decoder_monitor
    import dsd_pkg::*;
#(
    parameter bit LARGE = 1'b1
) (
    input wire logic                  clock,
    input wire logic                  rst_b,
    input wire logic                  req_valid,
    input wire dsd_req_t              req,
    input wire logic                  req_ready,
    input wire dsd_rsp_t              rsp,
    input wire logic [PC_W_LARGE-1:0] pc_next,
    input wire logic                  pc_load,
    input wire logic [PC_W_LARGE-1:0] program_counter,
    input wire logic                  ext_we,
    input wire logic [7:0]            ext_addr,
    input wire logic [7:0]            ext_wdata
);
    localparam logic [15:0] SL = LARGE ? SRAM_LAST_L : SRAM_LAST_S;
    localparam logic [11:0] PM = LARGE ? 12'h0FFF : 12'h07FF;
    logic take;
    logic dir;
    logic [15:0] a;
    assign take = req_valid && req_ready;
    assign a = req.addr;
    assign dir = take && req.mode == AM_DIRECT
        && (req.op == OP_LOAD || req.op == OP_STORE);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_sram_two_cycle: assert property (
        dir && a >= SRAM_FIRST && a <= SL |=> !req_ready && !rsp.valid
        ##1 rsp.valid && rsp.region == RG_SRAM)
        else $error("sram access timing or region wrong");
    a_wreg_region: assert property (
        dir && a <= WREG_LAST |=> rsp.valid && rsp.region == RG_WREG)
        else $error("working register region wrong");
    a_io_region: assert property (
        dir && a >= IO_FIRST && a <= IO_LAST |=> rsp.region == RG_IO)
        else $error("short peripheral region wrong");
    a_short_region: assert property (
        take && (req.op == OP_IO_LOAD || req.op == OP_IO_STORE)
        |=> rsp.valid && rsp.region == RG_IO)
        else $error("short op region wrong");
    a_ext_region: assert property (
        dir && a >= EXT_FIRST && a <= 16'h00BF |=> rsp.region == RG_EXT)
        else $error("extended region wrong");
    a_ext_store: assert property (
        dir && req.op == OP_STORE && a >= EXT_FIRST && a <= EXT_LAST
        |-> ext_we && ext_addr == a[7:0] && ext_wdata == req.wdata)
        else $error("extended store not passed on");
    a_short_no_ext: assert property (
        take && req.op != OP_STORE |-> !ext_we)
        else $error("extended write by wrong op");
    a_bit_refused: assert property (
        take && req.op inside {OP_BIT_SET, OP_BIT_CLR, OP_BIT_TST}
        && a[5:0] > BIT_IO_LAST
        |=> rsp.region == RG_NONE && rsp.rdata == 8'h00)
        else $error("bit op above low block not refused");
    a_pc_load: assert property (
        pc_load |=> program_counter == ($past(pc_next) & PM))
        else $error("program counter load wrong");
endmodule
bind dsd_decoder dsd_decoder_monitor #(.LARGE(LARGE)) u_monitor (
    .clock(clock), .rst_b(rst_b), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp(rsp), .pc_next(pc_next),
    .pc_load(pc_load), .program_counter(program_counter),
    .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata));
`default_nettype wire

/* dsd_ext_model.sv */
// Far-side model of the extended peripheral register bank.
`timescale 1ns/1ns
`default_nettype none
module dsd_ext_model
    import dsd_pkg::*;
#(
    parameter logic [7:0] IMPL_LAST = 8'hBF
) (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic [7:0]  ext_addr,
    input wire logic [7:0]  ext_wdata,
    input wire logic        ext_we,
    output logic [7:0]      ext_rdata,
    output logic            ext_hit
);
    logic [7:0] regs_q [0:255];
    logic [7:0] junk_q;
    assign ext_hit = ext_addr >= 8'h60 && ext_addr <= IMPL_LAST;
    // Unimplemented places show a value that changes every cycle.
    assign ext_rdata = ext_hit ? regs_q[ext_addr] : junk_q;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            junk_q <= 8'h5A;
        end else begin
            junk_q <= ~junk_q;
        end
    end
    always_ff @(posedge clock) begin
        if (ext_we && ext_hit) begin
            regs_q[ext_addr] <= ext_wdata;
        end
    end
endmodule
`default_nettype wire

/* data_space_address_decoder_bench.sv */
// Self-checking bench of the data space decoder.
`timescale 1ns/1ns
`default_nettype none
module data_space_address_decoder_bench;
    import dsd_pkg::*;
    logic        clock, rst_b, req_valid, req_ready, pc_load, prog_we;
    logic        ext_we, ext_hit;
    dsd_req_t    req;
    dsd_rsp_t    rsp, got;
    logic [11:0] pc_next, program_counter;
    logic [15:0] prog_word, prog_wdata;
    logic [7:0]  ext_wdata, ext_addr, ext_rdata;
    int          mismatches, samples_checked, cycles;

    dsd_decoder #(.LARGE(1'b1)) dut (.clock(clock), .rst_b(rst_b),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp(rsp), .pc_next(pc_next), .pc_load(pc_load),
        .program_counter(program_counter), .prog_word(prog_word),
        .prog_we(prog_we), .prog_wdata(prog_wdata),
        .ext_wdata(ext_wdata), .ext_addr(ext_addr), .ext_we(ext_we),
        .ext_rdata(ext_rdata), .ext_hit(ext_hit));
    dsd_ext_model u_ext (.clock(clock), .rst_b(rst_b),
        .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_we(ext_we),
        .ext_rdata(ext_rdata), .ext_hit(ext_hit));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input string w, input logic [15:0] e,
                         input logic [15:0] s);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", w, e, s);
        end
    endtask
    // One request, held until taken; the answer lands in got.
    task automatic access(input dsd_op_t op, input dsd_mode_t md,
        input dsd_ptr_t pt, input logic [15:0] a, input logic [7:0] wd,
        input logic [2:0] b = 3'h0, input logic [5:0] dp = 6'h00);
        int n;
        @(negedge clock);
        req = '{op, md, pt, a, dp, b, wd};
        req_valid = 1'b1;
        for (n = 0; n < 8 && req_ready !== 1'b1; n++) @(negedge clock);
        @(negedge clock);
        req_valid = 1'b0;
        for (n = 0; n < 4 && rsp.valid !== 1'b1; n++) @(negedge clock);
        if (n == 4) check("rsp_valid", 16'h0001, 16'h0000);
        got = rsp;
    endtask
    task automatic ld(input logic [15:0] a);
        access(OP_LOAD, AM_DIRECT, PS_A, a, 8'h00);
    endtask
    task automatic st(input logic [15:0] a, input logic [7:0] d);
        access(OP_STORE, AM_DIRECT, PS_A, a, d);
    endtask
    task automatic t_regions();
        logic [15:0] al [7] = '{16'h001F, 16'h0020, 16'h005F, 16'h0060,
                                16'h00BF, 16'h0100, 16'h02FF};
        dsd_region_t rl [7] = '{RG_WREG, RG_IO, RG_IO, RG_EXT, RG_EXT,
                                RG_SRAM, RG_SRAM};
        for (int i = 0; i < 7; i++) begin
            // Software never writes the reserved short place at 0x005F.
            if (al[i] != 16'h005F) begin
                st(al[i], al[i][7:0] ^ 8'hC3);
            end
            ld(al[i]);
            check("region", 16'(rl[i]), 16'(got.region));
            check("rdata", al[i] == 16'h005F ? 16'h0000
                  : 16'(al[i][7:0] ^ 8'hC3), 16'(got.rdata));
        end
        $display("test regions done");
    endtask
    task automatic t_short();
        access(OP_IO_STORE, AM_DIRECT, PS_A, 16'h0001, 8'h81);
        ld(16'h0021);
        check("scratch_data", 16'h0081, 16'(got.rdata));
        access(OP_BIT_SET, AM_DIRECT, PS_A, 16'h0001, 8'h00, 3'h3);
        access(OP_BIT_CLR, AM_DIRECT, PS_A, 16'h0001, 8'h00, 3'h0);
        access(OP_IO_LOAD, AM_DIRECT, PS_A, 16'h0001, 8'h00);
        check("bit_ops", 16'h0088, 16'(got.rdata));
        access(OP_BIT_TST, AM_DIRECT, PS_A, 16'h0001, 8'h00, 3'h7);
        check("bit_test1", 16'h0001, 16'(got.bit_val));
        access(OP_BIT_TST, AM_DIRECT, PS_A, 16'h0001, 8'h00, 3'h0);
        check("bit_test0", 16'h0000, 16'(got.bit_val));
        access(OP_BIT_SET, AM_DIRECT, PS_A, 16'h0020, 8'h00, 3'h1);
        check("bit_high", 16'(RG_NONE), 16'(got.region));
        access(OP_IO_LOAD, AM_DIRECT, PS_A, 16'h003F, 8'h00);
        check("unmapped_io", 16'h0000, 16'(got.rdata));
        ld(16'h00C0);
        check("unmapped_ext", 16'h0000, 16'(got.rdata));
        $display("test short done");
    endtask
    task automatic t_pointers();
        st(16'h001C, 8'h00);
        st(16'h001D, 8'h01);
        access(OP_STORE, AM_DISP, PS_B, 16'h0000, 8'h5A, 3'h0, 6'h3F);
        ld(16'h013F);
        check("disp", 16'h005A, 16'(got.rdata));
        access(OP_LOAD, AM_IND, PS_B, 16'h0000, 8'h00);
        check("indirect", 16'h00C3, 16'(got.rdata));
        st(16'h001A, 8'h21);
        st(16'h001B, 8'h00);
        access(OP_LOAD, AM_POSTINC, PS_A, 16'h0000, 8'h00);
        check("postinc_data", 16'h0088, 16'(got.rdata));
        ld(16'h001A);
        check("postinc_ptr", 16'h0022, 16'(got.rdata));
        st(16'h001E, 8'h23);
        st(16'h001F, 8'h00);
        access(OP_STORE, AM_PREDEC, PS_C, 16'h0000, 8'h77);
        access(OP_IO_LOAD, AM_DIRECT, PS_A, 16'h0002, 8'h00);
        check("predec_data", 16'h0077, 16'(got.rdata));
        ld(16'h001E);
        check("predec_ptr", 16'h0022, 16'(got.rdata));
        $display("test pointers done");
    endtask
    // Loads the counter, then writes one program word there.
    task automatic pcw(input logic [11:0] a, input logic [15:0] d);
        @(negedge clock);
        pc_next = a;
        pc_load = 1'b1;
        @(negedge clock);
        check("program_counter", 16'(a), 16'(program_counter));
        prog_we = 1'b1;
        prog_wdata = d;
        @(negedge clock);
        prog_we = 1'b0;
        @(negedge clock);
        check("prog_word", d, prog_word);
    endtask
    task automatic t_prog();
        pcw(12'hFFF, 16'hBEEF);
        pcw(12'h000, 16'h1234);
        pc_next = 12'hFFF;
        repeat (2) @(negedge clock);
        check("prog_top", 16'hBEEF, prog_word);
        pc_load = 1'b0;
        $display("test program done");
    endtask

    // Reset in mid-run clears the counter, the registers and the answer.
    task automatic t_reset();
        @(negedge clock);
        rst_b = 1'b0;
        @(negedge clock);
        rst_b = 1'b1;
        check("reset_pc", 16'h0000, 16'(program_counter));
        check("reset_ready", 16'h0001, 16'(req_ready));
        check("reset_valid", 16'h0000, 16'(rsp.valid));
        ld(16'h0020);
        check("reset_scratch", 16'h0000, 16'(got.rdata));
        ld(16'h001A);
        check("reset_pointer", 16'h0000, 16'(got.rdata));
        $display("test reset done");
    endtask

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_of_test();
        end
    end
    initial begin
        rst_b = 1'b0;
        req_valid = 1'b0;
        req = '0;
        pc_next = 12'h000;
        pc_load = 1'b0;
        prog_we = 1'b0;
        prog_wdata = 16'h0000;
        repeat (10) @(negedge clock);
        rst_b = 1'b1;
        t_regions();
        t_short();
        t_pointers();
        t_prog();
        t_reset();
        end_of_test();
    end
endmodule
`default_nettype wire
